// *** src/rcc_pkg.sv ***
// package for the reference comparator control block: offsets, fields, resets
package rcc_pkg;

  // register byte offsets on the wishbone bus, one aligned word each
  localparam logic [3:0] RCC_OFS_CS  = 4'h0;
  localparam logic [3:0] RCC_OFS_SEL = 4'h4;
  localparam logic [3:0] RCC_OFS_REF = 4'h8;
  localparam logic [3:0] RCC_OFS_PIN = 4'hC;

  // control/status field positions
  localparam int RCC_CS_ON    = 7;
  localparam int RCC_CS_FLAG  = 6;
  localparam int RCC_CS_OPE   = 4;
  localparam int RCC_CS_RES   = 3;
  localparam int RCC_CS_ES_HI = 2;
  localparam int RCC_CS_ES_LO = 1;
  localparam int RCC_CS_IRQ   = 0;

  // input select field positions
  localparam int RCC_SEL_POS_LO = 4;
  localparam int RCC_SEL_NEG_LO = 0;

  // reference generator field positions
  localparam int RCC_REF_ON  = 7;
  localparam int RCC_REF_SUP = 6;

  // writable bit masks, everything else reads zero except the control/status result bit
  localparam logic [7:0] RCC_MASK_CS  = 8'hD7;
  localparam logic [7:0] RCC_MASK_SEL = 8'h77;
  localparam logic [7:0] RCC_MASK_REF = 8'hDF;
  localparam logic [7:0] RCC_MASK_PIN = 8'h7F;

  localparam logic [7:0] RCC_RST_REG = 8'h00;

  // input select code that routes the reference generator
  localparam logic [2:0] RCC_SEL_REFGEN = 3'h7;

  // edge select encodings
  localparam logic [1:0] RCC_EDGE_BOTH = 2'h0;
  localparam logic [1:0] RCC_EDGE_FALL = 2'h1;
  localparam logic [1:0] RCC_EDGE_RISE = 2'h2;

  // ladder has 32 steps, output = full_scale * (level + 1) / 32
  localparam int RCC_REF_STEPS = 32;

  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] sel;
    logic [3:0] adr;
    logic [7:0] dat;
  } rcc_wb_req_t;

  typedef struct packed {
    logic       comparator_on;
    logic       refgen_on;
    logic       refgen_supply_sel;
    logic [4:0] refgen_level;
    logic [2:0] pos_input_sel;
    logic [2:0] neg_input_sel;
    logic [6:0] analog_pin_en;
  } rcc_analog_t;

  typedef struct packed {
    logic [7:0] cs;
    logic [7:0] sel;
    logic [7:0] ref_ctl;
    logic [7:0] pin;
    logic       sync1;
    logic       sync2;
    logic       sync3;
    logic       ack;
    logic [7:0] rdat;
  } rcc_state_t;

endpackage

// *** src/rcc_top.sv ***
// reference comparator control: wishbone registers, result sync, edge flag, wake
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
// Operation
// (R1) control bit 7 turns comparator on/off
// (R2) flag set two clocks after synced edge
// (R3) writing 0 clears flag, 1 keeps
// (R4) edge select: both, falling, rising, reserved
// (R5) result bit synced, zero when off/reset
// (R6) interrupt when flag and enable both set
// (R7) flag stays until software clears it
// (R8) positive select: inputs 0-6, 7 is reference
// (R9) negative select uses identical encoding
// (R10) reference generator enable bit 7
// (R11) supply select: 0 internal, 1 external
// (R12) level code sets (code+1)/32 of full scale
// (R13) seven pin enables gate external inputs
// (R14) output pin enable stored, no effect
// (R15) shallow stop: async edge wakes processor
// (R16) result holds while clock stopped
// (R17) shallow stop exit keeps settings, reset clears
// (R18) deep stop: shut down, wake resets
// (R19) reset disables comparator and generator
// (R20) runs normally in debug and wait
// (R21) software configures inputs before enabling
// (R22) software clears spurious flag before irq enable
// (R23) unused bits read zero, writes ignored
module rcc_top
  import rcc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // analog comparator core
  input  wire logic        cmp_out_i,
  output rcc_analog_t      analog_o,
  // power mode
  input  wire logic        shallow_stop_i,
  input  wire logic        deep_stop_i,
  // interrupt and wake
  output logic             irq_o,
  output logic             wake_o
);

  rcc_state_t q;
  rcc_state_t next_q;
  logic       hit;
  logic       wr;
  logic       edge_ok;

  ////////////////////////////////////////////////////////////////////////
  // edge qualifier, used for both synced flag and async wake
  function automatic logic rcc_edge(input logic [1:0] mode, input logic prev,
                                    input logic cur);
    logic rise;
    logic fall;
    rise = ~prev & cur;
    fall = prev & ~cur;
    unique case (mode)
      RCC_EDGE_BOTH: rcc_edge = rise | fall; // R4
      RCC_EDGE_FALL: rcc_edge = fall; // R4
      RCC_EDGE_RISE: rcc_edge = rise; // R4
      default:       rcc_edge = 1'b0; // R4
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  assign hit = cyc_i & stb_i & ~q.ack;
  // write lands on the edge where the master samples ack high
  assign wr  = cyc_i & stb_i & q.ack & we_i & sel_i[0];
  assign edge_ok = q.cs[RCC_CS_ON]
                 & rcc_edge(q.cs[RCC_CS_ES_HI:RCC_CS_ES_LO], q.sync3, q.sync2);

  always_comb begin
    next_q = q;
    next_q.ack = hit;
    // sync chain keeps its value simply because no edge arrives while stopped
    next_q.sync1 = cmp_out_i & q.cs[RCC_CS_ON]; // R16
    next_q.sync2 = q.sync1;
    next_q.sync3 = q.sync2;
    if (wr) begin
      unique case (adr_i)
        RCC_OFS_CS: begin
          next_q.cs = (dat_i[7:0] & RCC_MASK_CS) | (q.cs & ~RCC_MASK_CS); // R1 R14 R23
          next_q.cs[RCC_CS_FLAG] = q.cs[RCC_CS_FLAG] & dat_i[RCC_CS_FLAG]; // R3
        end
        RCC_OFS_SEL: next_q.sel = dat_i[7:0] & RCC_MASK_SEL; // R8 R9 R23
        RCC_OFS_REF: next_q.ref_ctl = dat_i[7:0] & RCC_MASK_REF; // R10 R11 R12
        RCC_OFS_PIN: next_q.pin = dat_i[7:0] & RCC_MASK_PIN; // R13 R23
        default: ;
      endcase
    end
    // set beats a simultaneous software clear
    if (edge_ok) begin
      next_q.cs[RCC_CS_FLAG] = 1'b1; // R2 R7
    end
    // input is synchronous, one flop is enough; flag trails this bit by two clocks
    next_q.cs[RCC_CS_RES] = next_q.sync1; // R2 R5
    next_q.rdat = RCC_RST_REG;
    if (hit && !we_i) begin
      unique case (adr_i)
        RCC_OFS_CS:  next_q.rdat = q.cs;
        RCC_OFS_SEL: next_q.rdat = q.sel;
        RCC_OFS_REF: next_q.rdat = q.ref_ctl;
        RCC_OFS_PIN: next_q.rdat = q.pin;
        default:     next_q.rdat = RCC_RST_REG; // R23
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    // deep stop wake comes in through a reset; both clear everything
    if (rst_i || deep_stop_i) begin
      q <= '0; // R17 R18 R19
    end else begin
      q <= next_q; // R17 R20
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign ack_o = q.ack;
  assign dat_o = {24'h000000, q.rdat};
  assign irq_o = q.cs[RCC_CS_FLAG] & q.cs[RCC_CS_IRQ]; // R6
  // combinational path so the edge can wake a stopped clock
  assign wake_o = shallow_stop_i & q.cs[RCC_CS_IRQ] & q.cs[RCC_CS_ON]
                & rcc_edge(q.cs[RCC_CS_ES_HI:RCC_CS_ES_LO], q.sync3, cmp_out_i); // R15

  // output pin enable bit drives nothing, no such pin exists (R14)
  assign analog_o.comparator_on     = q.cs[RCC_CS_ON]; // R1
  assign analog_o.refgen_on         = q.ref_ctl[RCC_REF_ON]; // R10
  assign analog_o.refgen_supply_sel = q.ref_ctl[RCC_REF_SUP]; // R11
  assign analog_o.refgen_level      = q.ref_ctl[4:0]; // R12
  assign analog_o.pos_input_sel     = q.sel[RCC_SEL_POS_LO +: 3]; // R8
  assign analog_o.neg_input_sel     = q.sel[RCC_SEL_NEG_LO +: 3]; // R9
  assign analog_o.analog_pin_en     = q.pin[6:0]; // R13

endmodule

// *** verification/rcc_asserts.sv ***
// port checker for rcc_top
`timescale 1ns/100ps
module rcc_asserts
  import rcc_pkg::*;
(
  // watched ports
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  input wire rcc_analog_t analog_o,
  input wire logic        shallow_stop_i,
  input wire logic        deep_stop_i,
  input wire logic        irq_o,
  input wire logic        wake_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || deep_stop_i);
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("dat busy");
  a_irq_hold: assert property (irq_o && !cyc_i |=> irq_o) else $error("irq lost");
  a_rst_off: assert property (disable iff (1'h0) rst_i |=> analog_o == '0 && !irq_o)
    else $error("reset left state");
  a_deep_off: assert property (disable iff (rst_i) deep_stop_i |=> analog_o == '0)
    else $error("deep stop left state");
  a_wake_gate: assert property (wake_o |-> shallow_stop_i && analog_o.comparator_on)
    else $error("stray wake");
  a_cfg_write: assert property ($changed(analog_o) |-> $past(ack_o))
    else $error("config moved");
  cover property (irq_o);
  cover property (wake_o);
  cover property (ack_o && dat_o != 32'h0);
endmodule
bind rcc_top rcc_asserts u_rcc_asserts (.*);

// *** verification/rcc_cmp_model.sv ***
// behavioural comparator core
`timescale 1ns/100ps
module rcc_cmp_model
  import rcc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire rcc_analog_t analog_i,
  input  wire logic        lvl_i,
  output logic             cmp_o
);
  // disabled core reads low; one clock stands in for settling
  always_ff @(posedge clk_i) cmp_o <= analog_i.comparator_on & lvl_i;
endmodule

// *** verification/tb_rcc_top.sv ***
// self-checking bench for rcc_top
`timescale 1ns/100ps
module tb_rcc_top
  import rcc_pkg::*;
;
  `define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin errors++; \
    $display("ERROR %s exp %h got %h", nm, e, s); end end
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, lvl = 0;
  logic        shallow_stop_i = 0, deep_stop_i = 0, ack_o, irq_o, wake_o, cmp_out_i;
  logic [3:0]  adr_i = 0, sel_i = 4'hF;
  logic [31:0] dat_i = 0, dat_o, seed = 32'h82C40163;
  logic [7:0]  q;
  rcc_analog_t analog_o;
  int          errors = 0, n_checks = 0, m[4];
  localparam logic [7:0] MSK[4] = '{RCC_MASK_CS, RCC_MASK_SEL, RCC_MASK_REF, RCC_MASK_PIN};
  rcc_top u_rcc_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .cmp_out_i, .analog_o, .shallow_stop_i, .deep_stop_i, .irq_o, .wake_o);
  rcc_cmp_model u_rcc_cmp_model (.clk_i, .analog_i(analog_o), .lvl_i(lvl), .cmp_o(cmp_out_i));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= {24'h0, d};
    // only the watchdog ends a wait for ack
    do @(posedge clk_i); while (ack_o !== 1'h1);
    q = dat_o[7:0];
    cyc_i <= 0; stb_i <= 0;
  endtask
  task automatic wr(input int i, input logic [7:0] d);
    wb(1, 4'(i * 4), d);
    m[i] = i ? d & MSK[i] : (d & 8'h97) | (m[0] & d & 8'h40);
  endtask
  task automatic rd(input int i);
    wb(0, 4'(i * 4), 0);
    `CHK("reg", 8'(m[i] | (i ? 0 : (lvl & m[0][7]) << 3)), q)
    `CHK("analog", {m[0][7], m[2][7:6], m[2][4:0], m[1][6:4], m[1][2:0], m[3][6:0]},
      analog_o)
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial forever #5 clk_i = ~clk_i;
  initial begin
    #300000;
    errors++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    foreach (m[i]) rd(i);
    wb(0, 4'h2, 0);
    `CHK("unmapped", 8'h0, q)
    // lane 0 disabled: the write must be dropped
    sel_i <= 4'hE;
    wb(1, RCC_OFS_SEL, 8'h55);
    sel_i <= 4'hF;
    rd(1);
    // comparator kept off while the rest is randomised
    for (int k = 0; k < 40; k++) begin
      wr(k % 4, 8'(xs()) & (k % 4 == 0 ? 8'h7F : 8'hFF));
      rd(k % 4);
    end
    // settle pins, reference and inputs before the comparator comes on
    wr(0, 8'h00);
    wr(3, 8'h3C);
    wr(2, 8'h4A);
    wr(2, 8'hCA);
    wr(1, 8'h75);
    // enable with irq off, wait, drop the spurious flag, then irq on
    wr(0, 8'h80);
    repeat (5) @(posedge clk_i);
    wr(0, 8'h80);
    // flag cleared each pass so one stale edge cannot mask the next
    for (int es = 0; es < 4; es++) begin
      wr(0, 8'h81 | 8'(es << 1));
      repeat (2) begin
        @(posedge clk_i);
        lvl <= ~lvl;
        repeat (6) @(posedge clk_i);
        if (es == 0 || es == (lvl ? 2 : 1)) m[0][6] = 1;
        wr(0, 8'hC1 | 8'(es << 1));
        rd(0);
        `CHK("irq", m[0][6], irq_o)
        wr(0, 8'h81 | 8'(es << 1));
      end
    end
    wr(0, 8'h81);
    shallow_stop_i <= 1;
    @(posedge clk_i);
    lvl <= 1;
    @(posedge clk_i);
    #1 `CHK("wake", 1'h1, wake_o)
    @(posedge clk_i);
    shallow_stop_i <= 0;
    for (int i = 1; i < 4; i++) rd(i);
    deep_stop_i <= 1;
    repeat (2) @(posedge clk_i);
    deep_stop_i <= 0;
    foreach (m[i]) m[i] = 0;
    foreach (m[i]) rd(i);
    finish_test();
  end
endmodule
